// ---- gpb_pin_bank.sv ----
/*
 * General purpose pin control bank for pins 2.1 to 3.2: one control byte per
 * pin, an AHB-Lite slave for the registers, and the pin multiplexer that
 * joins each pin either to plain GPIO or to one of its alternate functions; pin 2.4 has none.
 * Assumes a single 250 MHz clock, pins that are asynchronous to it, and
 * alternate-function units that run on the same clock.
 */
// Overview of operation
// RQ1 - Control bit 0 sets direction, 1 for input and 0 for output.
// RQ2 - Control bit 1 set inverts the pin's logical value, clear passes it.
// RQ3 - Control bit 7 set gives an open-drain driver, clear a push-pull one.
// RQ4 - Pin 2.1 select bits 3:2 pick drive select 1, edge irq 0, kbc bit 6 or GPIO.
// RQ5 - Pin 2.2 select bits 3:2 pick motor select 1, edge irq 1, kbc bit 2 or GPIO.
// RQ6 - Bits 6:4 of two-bit select registers and 6:3 of one-bit ones are reserved.
// RQ7 - The location at 2E holds no pin and always reads zero.
// RQ8 - Pin 2.4 has no alternate function and its bit 2 is reserved.
// RQ9 - In one-bit select registers bit 2 set picks the alternate function.
// RQ10 - Pin 2.5 alternate select connects it to the music serial receive input.
// RQ11 - Pin 2.6 alternate select drives the music serial transmit output.
// RQ12 - Pin 2.7 alternate select drives the active-low management interrupt.
// RQ13 - Pin 3.0 alternate select feeds the second tachometer input.
// RQ14 - Pin 3.1 alternate select feeds the first tachometer input.
// RQ15 - Pin 3.2 alternate select drives the second fan speed output.
// RQ16 - Standby reset loads 01 into each pin register, main reset clears 3.2.

`include "gpb_cfg.svh"

module gpb_pin_bank (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  vcc_reset_n,
    input  wire logic [8:0]            pin_in,
    output logic [8:0]                 pin_out,
    output logic [8:0]                 pin_oe,
    input  wire gpb_pkg::gpb_alt_src_t alt_src,
    output gpb_pkg::gpb_alt_snk_t      alt_snk
);

    // ************************************************************
    // decode helpers
    // ************************************************************

    // map a word index onto a pin number, or no pin at all
    function automatic logic [3:0] gpb_pin_of(input logic [9:0] idx);
        case (idx)
            `GPB_IDX_2_1: gpb_pin_of = 4'h0;
            `GPB_IDX_2_2: gpb_pin_of = 4'h1;
            `GPB_IDX_2_4: gpb_pin_of = 4'h2;
            `GPB_IDX_2_5: gpb_pin_of = 4'h3;
            `GPB_IDX_2_6: gpb_pin_of = 4'h4;
            `GPB_IDX_2_7: gpb_pin_of = 4'h5;
            `GPB_IDX_3_0: gpb_pin_of = 4'h6;
            `GPB_IDX_3_1: gpb_pin_of = 4'h7;
            `GPB_IDX_3_2: gpb_pin_of = 4'h8;
            default:      gpb_pin_of = `GPB_NO_PIN;
        endcase
    endfunction

    // writable bits of each pin register; reserved bits stay zero
    function automatic logic [7:0] gpb_wmask(input logic [3:0] p);
        case (p)
            4'h0, 4'h1: gpb_wmask = `GPB_MASK_SEL2;   // [RQ6]
            4'h2:       gpb_wmask = `GPB_MASK_NOSEL;  // [RQ8]
            default:    gpb_wmask = `GPB_MASK_SEL1;   // [RQ6]
        endcase
    endfunction

    // ************************************************************
    // state
    // ************************************************************
    gpb_pkg::gpb_state_t st;
    gpb_pkg::gpb_state_t next_st;

    logic [3:0] wp;
    logic [3:0] rp;
    logic [1:0] sel0;
    logic [1:0] sel1;
    logic [8:0] aout;
    logic [8:0] aval;
    logic [8:0] pol;
    logic [8:0] seen;
    logic [31:0] rd;
    logic       drv;
    logic       v;

    // ************************************************************
    // next-state logic
    // ************************************************************

    // bus, synchronisers, register updates and pin multiplexer in one pass
    always_comb begin
        next_st = st;
        wp      = gpb_pin_of(st.dph_idx);
        rp      = gpb_pin_of(haddr[11:2]);
        rd      = 32'h0000_0000;
        drv     = 1'b0;
        v       = 1'b0;

        // pins and main reset are asynchronous: two flops before any use
        next_st.meta      = pin_in;
        next_st.sync      = st.meta;
        next_st.vrst_meta = vcc_reset_n;
        next_st.vrst_sync = st.vrst_meta;

        // data phase of a write: reserved bits are masked off on the way in
        if (st.dph_wr) begin
            if (wp != `GPB_NO_PIN) begin
                next_st.ctrl[wp] = hwdata[7:0] & gpb_wmask(wp);  // [RQ6] [RQ8]
            end else if (st.dph_idx == `GPB_IDX_DATA) begin
                next_st.data = hwdata[8:0];
            end
        end

        // main supply reset overrides a write landing in the same cycle
        if (!st.vrst_sync) begin
            next_st.ctrl[8] = `GPB_RST_MAIN_3_2;  // [RQ16]
        end

        // address phase: read data is taken from the updated copy so a read
        // right behind a write to the same register sees the new value
        next_st.dph_wr = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_st.dph_wr  = hwrite;
            next_st.dph_idx = haddr[11:2];
            if (!hwrite) begin
                if (rp != `GPB_NO_PIN) begin
                    rd[7:0] = next_st.ctrl[rp];
                end else if (haddr[11:2] == `GPB_IDX_DATA) begin
                    rd[8:0] = next_st.data;
                end else if (haddr[11:2] == `GPB_IDX_LEVEL) begin
                    rd[8:0] = st.sync;
                end
                // the 2E slot and unmapped words fall through as zero  [RQ7]
                next_st.rdata = rd;
            end
        end
        next_st.ready = 1'b1;

        // alternate outputs per pin; input-only functions drive nothing
        sel0 = st.ctrl[0][`GPB_SEL_HI:`GPB_SEL_LO];
        sel1 = st.ctrl[1][`GPB_SEL_HI:`GPB_SEL_LO];
        aout = 9'h000;
        aval = 9'h000;
        aout[0] = (sel0 == 2'b11) || (sel0 == 2'b01);                     // [RQ4]
        aval[0] = (sel0 == 2'b11) ? alt_src.floppy_drive_sel_1_n
                                  : alt_src.kbc_port_bit_6;               // [RQ4]
        aout[1] = (sel1 == 2'b11) || (sel1 == 2'b01);                     // [RQ5]
        aval[1] = (sel1 == 2'b11) ? alt_src.floppy_motor_sel_1_n
                                  : alt_src.kbc_port_bit_2;               // [RQ5]
        aout[4] = st.ctrl[4][`GPB_SEL_LO];                                // [RQ9] [RQ11]
        aval[4] = alt_src.music_serial_tx;                                // [RQ11]
        aout[5] = st.ctrl[5][`GPB_SEL_LO];                                // [RQ12]
        aval[5] = alt_src.system_mgmt_irq_out_n;                          // [RQ12]
        aout[8] = st.ctrl[8][`GPB_SEL_LO];                                // [RQ15]
        aval[8] = alt_src.fan_speed_out_2;                                // [RQ15]

        // driver per pin: an alternate output forces the driver on,
        // otherwise the direction bit decides
        for (int i = 0; i < 9; i++) begin
            pol[i] = st.ctrl[i][`GPB_POL_BIT];
            drv    = aout[i] ? 1'b1 : !st.ctrl[i][`GPB_DIR_BIT];           // [RQ1]
            v      = (aout[i] ? aval[i] : st.data[i]) ^ pol[i];           // [RQ2]
            // open drain only ever pulls low; a one releases the wire
            next_st.poe[i]  = drv && (!st.ctrl[i][`GPB_OD_BIT] || !v);    // [RQ3]
            next_st.pout[i] = v && !st.ctrl[i][`GPB_OD_BIT];              // [RQ3]
        end

        // inputs toward the units, after the polarity stage
        seen = st.sync ^ pol;                                             // [RQ2]
        next_st.snk.edge_irq_in_0   = (sel0 == 2'b10) && seen[0];         // [RQ4]
        next_st.snk.edge_irq_in_1   = (sel1 == 2'b10) && seen[1];         // [RQ5]
        // keyboard port bits idle high as a released open-drain line would
        next_st.snk.kbc_port_bit_6  = (sel0 == 2'b01) ? seen[0] : 1'b1;   // [RQ4]
        next_st.snk.kbc_port_bit_2  = (sel1 == 2'b01) ? seen[1] : 1'b1;   // [RQ5]
        // a deselected receive line rests at the idle mark level
        next_st.snk.music_serial_rx = st.ctrl[3][`GPB_SEL_LO] ? seen[3] : 1'b1;  // [RQ10]
        next_st.snk.tachometer_in_2 = st.ctrl[6][`GPB_SEL_LO] && seen[6]; // [RQ13]
        next_st.snk.tachometer_in_1 = st.ctrl[7][`GPB_SEL_LO] && seen[7]; // [RQ14]
    end

    // ************************************************************
    // state register
    // ************************************************************

    // standby reset: every pin an input, no inversion, GPIO, push-pull
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st           <= '0;
            st.ctrl      <= {9{`GPB_RST_CTRL}};  // [RQ16]
            st.vrst_meta <= 1'b1;
            st.vrst_sync <= 1'b1;
            st.ready     <= 1'b1;
            st.snk       <= `GPB_RST_SNK;  // [RQ16]
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // outputs
    // ************************************************************
    assign hreadyout = st.ready;
    assign hresp     = 1'b0;
    assign hrdata    = st.rdata;
    assign pin_out   = st.pout;
    assign pin_oe    = st.poe;
    assign alt_snk   = st.snk;

    // ************************************************************
    // checks
    // ************************************************************

    // an input pin with no alternate output never drives
    chk_dir_input_quiet: assert property (  // [RQ1]
        @(posedge hclk) disable iff (!hresetn)
        st.ctrl[2][0] |=> !pin_oe[2])
        else $error("pin 2.4 drives while set as input");

    // push-pull output shows data xor polarity
    chk_polarity_applied: assert property (  // [RQ2]
        @(posedge hclk) disable iff (!hresetn)
        (!st.ctrl[2][0] && !st.ctrl[2][7])
        |=> pin_oe[2] && (pin_out[2] == ($past(st.data[2]) ^ $past(st.ctrl[2][1]))))
        else $error("pin 2.4 output value ignores polarity");

    // open-drain never drives a high level
    chk_open_drain_low: assert property (  // [RQ3]
        @(posedge hclk) disable iff (!hresetn)
        st.ctrl[6][7] |=> !(pin_oe[6] && pin_out[6]))
        else $error("open-drain pin drove high");

    // drive select routed onto pin 2.1
    chk_drive_sel_route: assert property (  // [RQ4]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[0][3:2] == 2'b11 && !st.ctrl[0][7])
        |=> pin_oe[0]
            && (pin_out[0] == ($past(alt_src.floppy_drive_sel_1_n) ^ $past(st.ctrl[0][1]))))
        else $error("drive select not on pin 2.1");

    // either-edge interrupt 1 follows the synchronised pin 2.2
    chk_edge_irq_route: assert property (  // [RQ5]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[1][3:2] == 2'b10)
        |=> alt_snk.edge_irq_in_1 == ($past(st.sync[1]) ^ $past(st.ctrl[1][1])))
        else $error("edge interrupt 1 not fed from pin 2.2");

    // a read of the empty slot answers zero in its data phase
    chk_slot_reads_zero: assert property (  // [RQ7]
        @(posedge hclk) disable iff (!hresetn)
        (hsel && htrans[1] && hready && !hwrite && haddr[11:2] == `GPB_IDX_RSVD_2E)
        |=> hrdata == 32'h0000_0000)
        else $error("reserved slot read not zero");

    // reserved bits never hold a one
    chk_reserved_clear: assert property (  // [RQ6] [RQ8]
        @(posedge hclk) disable iff (!hresetn)
        $rose(st.dph_wr) |=> (st.ctrl[0][6:4] == 3'h0) && (st.ctrl[2][6:2] == 5'h00)
                             && (st.ctrl[5][6:3] == 4'h0))
        else $error("reserved control bit set");

    // management interrupt driven on pin 2.7 when selected
    chk_smi_route: assert property (  // [RQ12]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[5][2] && !st.ctrl[5][7])
        |=> pin_oe[5]
            && (pin_out[5] == ($past(alt_src.system_mgmt_irq_out_n) ^ $past(st.ctrl[5][1]))))
        else $error("management interrupt not on pin 2.7");

    // main supply reset clears pin 3.2 and keeps it clear while held
    chk_main_reset_clear: assert property (  // [RQ16]
        @(posedge hclk) disable iff (!hresetn)
        (!st.vrst_sync ##1 !st.vrst_sync) |-> st.ctrl[8] == `GPB_RST_MAIN_3_2)
        else $error("pin 3.2 register not cleared by main reset");

    // motor select routed onto pin 2.2
    chk_motor_sel_route: assert property (  // [RQ5]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[1][3:2] == 2'b11 && !st.ctrl[1][7])
        |=> pin_oe[1]
            && (pin_out[1] == ($past(alt_src.floppy_motor_sel_1_n) ^ $past(st.ctrl[1][1]))))
        else $error("motor select not on pin 2.2");

    // keyboard port bit 6 fed from pin 2.1
    chk_kbc_bit6_route: assert property (  // [RQ4]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[0][3:2] == 2'b01)
        |=> alt_snk.kbc_port_bit_6 == ($past(st.sync[0]) ^ $past(st.ctrl[0][1])))
        else $error("keyboard bit 6 not fed from pin 2.1");

    // either-edge interrupt 0 fed from pin 2.1
    chk_edge_irq0_route: assert property (  // [RQ4]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[0][3:2] == 2'b10)
        |=> alt_snk.edge_irq_in_0 == ($past(st.sync[0]) ^ $past(st.ctrl[0][1])))
        else $error("edge interrupt 0 not fed from pin 2.1");

    // plain GPIO output on a one-bit select pin ignores the unit
    chk_gpio_sel_off: assert property (  // [RQ9]
        @(posedge hclk) disable iff (!hresetn)
        (!st.ctrl[4][2] && !st.ctrl[4][0] && !st.ctrl[4][7])
        |=> pin_oe[4]
            && (pin_out[4] == ($past(st.data[4]) ^ $past(st.ctrl[4][1]))))
        else $error("pin 2.6 not plain GPIO with select clear");

    // receive input fed from pin 2.5
    chk_rx_route: assert property (  // [RQ10]
        @(posedge hclk) disable iff (!hresetn)
        st.ctrl[3][2]
        |=> alt_snk.music_serial_rx == ($past(st.sync[3]) ^ $past(st.ctrl[3][1])))
        else $error("receive input not fed from pin 2.5");

    // transmit output routed onto pin 2.6
    chk_tx_route: assert property (  // [RQ11]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[4][2] && !st.ctrl[4][7])
        |=> pin_oe[4]
            && (pin_out[4] == ($past(alt_src.music_serial_tx) ^ $past(st.ctrl[4][1]))))
        else $error("transmit output not on pin 2.6");

    // second tachometer fed from pin 3.0
    chk_tach2_route: assert property (  // [RQ13]
        @(posedge hclk) disable iff (!hresetn)
        st.ctrl[6][2]
        |=> alt_snk.tachometer_in_2 == ($past(st.sync[6]) ^ $past(st.ctrl[6][1])))
        else $error("second tachometer not fed from pin 3.0");

    // first tachometer fed from pin 3.1
    chk_tach1_route: assert property (  // [RQ14]
        @(posedge hclk) disable iff (!hresetn)
        st.ctrl[7][2]
        |=> alt_snk.tachometer_in_1 == ($past(st.sync[7]) ^ $past(st.ctrl[7][1])))
        else $error("first tachometer not fed from pin 3.1");

    // fan speed output routed onto pin 3.2
    chk_fan_route: assert property (  // [RQ15]
        @(posedge hclk) disable iff (!hresetn)
        (st.ctrl[8][2] && !st.ctrl[8][7])
        |=> pin_oe[8]
            && (pin_out[8] == ($past(alt_src.fan_speed_out_2) ^ $past(st.ctrl[8][1]))))
        else $error("fan speed output not on pin 3.2");

endmodule

// ---- gpb_cfg.svh ----
/*
 * Constants for the general purpose pin control bank: register indices,
 * field positions, write masks and reset values.
 * Assumes it is included by its bare name wherever these values are used.
 */
`ifndef GPB_CFG_SVH
`define GPB_CFG_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define GPB_IDX_2_1        10'h02C
`define GPB_IDX_2_2        10'h02D
`define GPB_IDX_RSVD_2E    10'h02E
`define GPB_IDX_2_4        10'h02F
`define GPB_IDX_2_5        10'h030
`define GPB_IDX_2_6        10'h031
`define GPB_IDX_2_7        10'h032
`define GPB_IDX_3_0        10'h033
`define GPB_IDX_3_1        10'h034
`define GPB_IDX_3_2        10'h035
`define GPB_IDX_DATA       10'h040
`define GPB_IDX_LEVEL      10'h041

// ************************************************************
// field positions and masks
// ************************************************************
`define GPB_DIR_BIT        0
`define GPB_POL_BIT        1
`define GPB_SEL_LO         2
`define GPB_SEL_HI         3
`define GPB_OD_BIT         7
`define GPB_MASK_SEL2      8'h8F
`define GPB_MASK_SEL1      8'h87
`define GPB_MASK_NOSEL     8'h83
`define GPB_NO_PIN         4'hF

// ************************************************************
// reset values
// ************************************************************
`define GPB_RST_CTRL       8'h01
`define GPB_RST_MAIN_3_2   8'h00
`define GPB_RST_SNK        7'h1C   // kbc bits and receive line rest high

`endif

// ---- gpb_pkg.sv ----
/*
 * Types for the general purpose pin control bank: the bundles that run
 * between the pins and the alternate-function units, and the block state.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package gpb_pkg;

    // signals the alternate-function units send toward the pins
    typedef struct packed {
        logic floppy_drive_sel_1_n;
        logic floppy_motor_sel_1_n;
        logic kbc_port_bit_6;
        logic kbc_port_bit_2;
        logic music_serial_tx;
        logic system_mgmt_irq_out_n;
        logic fan_speed_out_2;
    } gpb_alt_src_t;

    // signals the pins deliver to the alternate-function units
    typedef struct packed {
        logic edge_irq_in_0;
        logic edge_irq_in_1;
        logic kbc_port_bit_6;
        logic kbc_port_bit_2;
        logic music_serial_rx;
        logic tachometer_in_1;
        logic tachometer_in_2;
    } gpb_alt_snk_t;

    // whole state of the bank, registered as one word
    typedef struct packed {
        logic [8:0][7:0] ctrl;
        logic [8:0]      data;
        logic [8:0]      meta;
        logic [8:0]      sync;
        logic            vrst_meta;
        logic            vrst_sync;
        logic            dph_wr;
        logic [9:0]      dph_idx;
        logic [31:0]     rdata;
        logic            ready;
        logic [8:0]      pout;
        logic [8:0]      poe;
        gpb_alt_snk_t    snk;
    } gpb_state_t;

endpackage

// ---- gpb_board_model.sv ----
/*
 * Board model for the far side of the pin bank: resolves each pin wire from
 * the bank's driver and the board's own driver, and feeds the level back.
 * Assumes the bench chooses what the board drives; no pull resistors.
 */
module gpb_board_model (
    input  wire logic       hclk,
    input  wire logic [8:0] pin_out,
    input  wire logic [8:0] pin_oe,
    input  wire logic [8:0] board_val,
    input  wire logic [8:0] board_en,
    output logic [8:0]      pin_in
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0] float_pat = 9'h0AA;

    // a line nobody drives shows a changing pattern, so no stale value can pass
    always @(posedge hclk) begin
        float_pat <= ~float_pat;
    end

    // the bank wins on contention; otherwise the board, otherwise the float pattern
    always_comb begin
        for (int i = 0; i < 9; i++) begin
            pin_in[i] = pin_oe[i] ? pin_out[i] : (board_en[i] ? board_val[i] : float_pat[i]);
        end
    end
endmodule

// ---- tb_top.sv ----
/*
 * Self-checking bench for the pin bank: AHB-Lite register access, a
 * behavioural model of pins and sinks, and random pin and function traffic.
 * Assumes gpb_cfg.svh, gpb_pkg and the board model are compiled first.
 */
`include "gpb_cfg.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  hclk = 1'b0;
    logic                  hresetn, hsel, hwrite, vcc_reset_n, hreadyout, hresp;
    logic [31:0]           haddr, hwdata, hrdata;
    logic [1:0]            htrans;
    logic [2:0]            hsize;
    logic [8:0]            pin_in, pin_out, pin_oe, board_val, board_en;
    gpb_pkg::gpb_alt_src_t alt_src;
    gpb_pkg::gpb_alt_snk_t alt_snk;
    int                    err_total, num_checks, data_m;
    logic [7:0]            ctrl_m [9];
    logic [15:0]           lfsr_s = 16'hE4BA;
    int idx_a [10] = '{`GPB_IDX_2_1, `GPB_IDX_2_2, `GPB_IDX_RSVD_2E, `GPB_IDX_2_4, `GPB_IDX_2_5,
                       `GPB_IDX_2_6, `GPB_IDX_2_7, `GPB_IDX_3_0, `GPB_IDX_3_1, `GPB_IDX_3_2};
    logic [7:0] mask_a [10] = '{8'h8F, 8'h8F, 8'h00, 8'h83, 8'h87,
                                8'h87, 8'h87, 8'h87, 8'h87, 8'h87};

    // ********************************************************
    // clock, design and board
    // ********************************************************
    always #2 hclk = ~hclk;

    gpb_pin_bank u_gpb_pin_bank (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .vcc_reset_n(vcc_reset_n),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt_src(alt_src),
        .alt_snk(alt_snk));

    gpb_board_model u_gpb_board_model (.hclk(hclk), .pin_out(pin_out), .pin_oe(pin_oe),
        .board_val(board_val), .board_en(board_en), .pin_in(pin_in));

    // ********************************************************
    // helpers
    // ********************************************************
    function automatic logic [15:0] rnd();
        lfsr_s = {lfsr_s[14:0], lfsr_s[15] ^ lfsr_s[13] ^ lfsr_s[12] ^ lfsr_s[10]};
        return lfsr_s;
    endfunction

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // one single word transfer; waits on hready, no fixed latency assumed
    task automatic bus(input logic wr, input int idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= 32'(idx * 4);
        htrans <= 2'h2;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr_reg(input int idx, input logic [31:0] wd);
        logic [31:0] rd;
        bus(1'b1, idx, wd, rd);
    endtask

    task automatic rd_chk(input int idx, input logic [31:0] exp);
        logic [31:0] rd;
        bus(1'b0, idx, 32'h0, rd);
        check(rd, exp, "register read");
        check(32'(hresp), 32'h0000_0000, "bus response");
    endtask

    // model of one pin: returns {enable, level, resolved wire}
    function automatic logic [2:0] model_pin(input int p);
        logic [7:0] c;
        logic [1:0] sel;
        logic       isalt, altv, v, oe;
        c = ctrl_m[p];
        sel = (p < 2) ? c[3:2] : {1'b0, c[2] & (p != 2)};
        isalt = (p < 2) ? sel[0] : ((p == 4 || p == 5 || p == 8) && sel[0]);
        case (p)
            0:       altv = sel[1] ? alt_src.floppy_drive_sel_1_n : alt_src.kbc_port_bit_6;
            1:       altv = sel[1] ? alt_src.floppy_motor_sel_1_n : alt_src.kbc_port_bit_2;
            4:       altv = alt_src.music_serial_tx;
            5:       altv = alt_src.system_mgmt_irq_out_n;
            default: altv = alt_src.fan_speed_out_2;
        endcase
        v = (isalt ? altv : data_m[p]) ^ c[1];
        oe = (isalt | ~c[0]) & (~c[7] | ~v);
        return {oe, v & ~c[7], oe ? v & ~c[7] : board_val[p]};
    endfunction

    // compares every pin driver, every sink and the raw level register
    task automatic check_all();
        logic [2:0]            m;
        logic [8:0]            w, s;
        gpb_pkg::gpb_alt_snk_t e;
        for (int p = 0; p < 9; p++) begin
            m = model_pin(p);
            w[p] = m[0];
            s[p] = m[0] ^ ctrl_m[p][1];
            check(32'(pin_oe[p]), 32'(m[2]), "pin enable");
            if (m[2]) check(32'(pin_out[p]), 32'(m[1]), "pin level");
        end
        e.edge_irq_in_0 = (ctrl_m[0][3:2] == 2'h2) ? s[0] : 1'b0;
        e.edge_irq_in_1 = (ctrl_m[1][3:2] == 2'h2) ? s[1] : 1'b0;
        e.kbc_port_bit_6 = (ctrl_m[0][3:2] == 2'h1) ? s[0] : 1'b1;
        e.kbc_port_bit_2 = (ctrl_m[1][3:2] == 2'h1) ? s[1] : 1'b1;
        e.music_serial_rx = ctrl_m[3][2] ? s[3] : 1'b1;
        e.tachometer_in_1 = ctrl_m[7][2] ? s[7] : 1'b0;
        e.tachometer_in_2 = ctrl_m[6][2] ? s[6] : 1'b0;
        check(32'(alt_snk), 32'(e), "sinks");
        rd_chk(`GPB_IDX_LEVEL, 32'(w));
    endtask

    task automatic finish_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ********************************************************
    // main sequence
    // ********************************************************
    initial begin
        logic [15:0] r;
        logic [7:0]  c;
        int          p;
        {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        vcc_reset_n = 1'b1;
        alt_src = '0;
        board_val = 9'h000;
        board_en = 9'h1FF;
        repeat (12) @(posedge hclk);
        check(32'(pin_oe), 32'h0000_0000, "drivers in reset");
        check(32'(alt_snk), 32'h0000_001C, "sinks in reset");
        hresetn <= 1'b1;
        data_m = 0;
        // reset values, then every writable bit set; reserved bits and the empty slot stay 0
        for (int i = 0; i < 10; i++) rd_chk(idx_a[i], (i == 2) ? 32'h0 : 32'h1);
        for (int i = 0; i < 10; i++) wr_reg(idx_a[i], 32'h0000_00FF);
        for (int i = 0; i < 10; i++) rd_chk(idx_a[i], 32'(mask_a[i]));
        wr_reg(10'h3FF, 32'hFFFF_FFFF);
        rd_chk(10'h3FF, 32'h0);
        for (int i = 0; i < 9; i++) ctrl_m[i] = mask_a[(i < 2) ? i : i + 1];
        repeat (6) @(posedge hclk);
        check_all();
        // random configurations; select codes walk through every value per pin
        for (int k = 0; k < 54; k++) begin
            p = k % 9;
            r = rnd();
            c = r[7:0];
            c[3:2] = (p < 2) ? 2'((k / 9) % 4) : {c[3], 1'(k / 9)};
            if (k >= 27) c[7] = 1'b0; // push-pull half, so routing checks see drive
            wr_reg(idx_a[(p < 2) ? p : p + 1], 32'(c));
            ctrl_m[p] = c & mask_a[(p < 2) ? p : p + 1];
            r = rnd();
            data_m = int'(r[8:0]);
            wr_reg(`GPB_IDX_DATA, 32'(data_m));
            rd_chk(`GPB_IDX_DATA, 32'(data_m));
            r = rnd();
            alt_src <= gpb_pkg::gpb_alt_src_t'(r[6:0]);
            board_val <= r[15:7];
            repeat (6) @(posedge hclk);
            rd_chk(idx_a[(p < 2) ? p : p + 1], 32'(ctrl_m[p]));
            check_all();
        end
        // main-supply reset clears pin 3.2 only, and beats a write made meanwhile
        @(posedge hclk);
        vcc_reset_n <= 1'b0;
        repeat (4) @(posedge hclk);
        wr_reg(`GPB_IDX_3_2, 32'h0000_0087);
        ctrl_m[8] = 8'h00;
        rd_chk(`GPB_IDX_3_2, 32'h0);
        rd_chk(`GPB_IDX_3_1, 32'(ctrl_m[7]));
        vcc_reset_n <= 1'b1;
        repeat (6) @(posedge hclk);
        check_all();
        finish_test();
    end

    // watchdog: the whole sequence needs about 1300 cycles
    initial begin
        repeat (40000) @(posedge hclk);
        err_total++;
        finish_test();
    end
endmodule
